// ---- hdl/tac_pkg.sv ----
// Constants, types and register map of the transfer activation control.
package tac_pkg;
  localparam int NSRC = 48;
  localparam int NSLOT = 6;
  localparam int NSET = 24;
  localparam int NFLAG = 5;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_ACTL = 8'h80;
  localparam logic [7:0] IDX_EN [NSLOT] = '{8'h88, 8'h89, 8'h8A, 8'h8B,
                                            8'h8D, 8'h8E};
  localparam logic [7:0] ACTL_RESET = 8'h00;
  localparam int ACTL_RSVD = 0;
  localparam int ACTL_EVT = 1;
  // Memory map of the vector table and control data area.
  localparam logic [15:0] VEC_BASE = 16'h2C00;
  localparam logic [15:0] CD_BASE = 16'h2C40;
  // Control data byte offsets inside one eight-byte set.
  localparam logic [2:0] CD_CCR = 3'h0;
  localparam logic [2:0] CD_CCT = 3'h2;
  localparam logic [2:0] CD_RLD = 3'h3;
  localparam logic [2:0] CD_SAL = 3'h4;
  localparam logic [2:0] CD_SAH = 3'h5;
  localparam logic [2:0] CD_DAL = 3'h6;
  localparam logic [2:0] CD_DAH = 3'h7;
  // Set control byte fields.
  localparam int CCR_RPT = 0;
  localparam int CCR_RPT_IRQ = 1;
  localparam int CCR_CHAIN = 2;
  localparam int CCR_SINC = 3;
  localparam int CCR_DINC = 4;
  localparam logic [7:0] CNT_LAST = 8'h01;
  // Sources whose peripheral flag is cleared during operation.
  localparam logic [5:0] SRC_TMR_A = 6'h11;
  localparam logic [5:0] SRC_TMR_B = 6'h10;
  localparam logic [5:0] SRC_TMR_C = 6'h1F;
  localparam logic [5:0] SRC_TMR_D = 6'h1E;
  localparam logic [5:0] SRC_FLASH = 6'h2B;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_VEC = 3'b001,
    S_FETCH = 3'b010,
    S_DREAD = 3'b011,
    S_DWRITE = 3'b100,
    S_BACK = 3'b101,
    S_END = 3'b110
  } tac_state_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tac_mem_op_t;

  typedef struct packed {
    logic wdt;
    logic osc;
    logic vm1;
    logic vm2;
  } tac_nmi_t;
endpackage

// ---- hdl/tac_arb.sv ----
// Fixed-priority selection among pending activation requests.
`timescale 1ns/10ps
module tac_arb (
  // Pending requests.
  input wire logic [tac_pkg::NSRC-1:0] pend,
  // Selected source.
  output logic gnt_vld,
  output logic [5:0] gnt_idx
);
  import tac_pkg::*;

  // The last match in the loop wins, so register 0 bit 7 ranks highest.
  function automatic logic [6:0] pick(input logic [NSRC-1:0] p);
    logic [6:0] r;
    r = 7'h00;
    for (int s = NSLOT - 1; s >= 0; s--) begin
      for (int b = 0; b < 8; b++) begin
        if (p[s * 8 + b]) begin
          r = {1'h1, 6'(s * 8 + b)};
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    {gnt_vld, gnt_idx} = pick(pend);
  end
endmodule

// ---- hdl/tac_mem.sv ----
// Byte memory master that runs one read or write per request.
`timescale 1ns/10ps
module tac_mem (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side.
  input wire logic go,
  input wire tac_pkg::tac_mem_op_t op,
  output logic done_q,
  output logic [7:0] rdata_q,
  // Memory side.
  output logic mem_req_q,
  output tac_pkg::tac_mem_op_t mem_op_q,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import tac_pkg::*;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_q <= 1'h0;
      mem_op_q <= '0;
      done_q <= 1'h0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= 1'h0;
      if (mem_req_q && mem_ack) begin
        mem_req_q <= 1'h0;
        done_q <= 1'h1;
        rdata_q <= mem_rdata;
      end else if (go && !mem_req_q) begin
        mem_req_q <= 1'h1;
        mem_op_q <= op;
      end
    end
  end
endmodule

// ---- hdl/tac_top.sv ----
// Transfer activation control: register slave, arbitration, sequencer.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module tac_top (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Peripheral events.
  input wire logic [tac_pkg::NSRC-1:0] irq_src,
  input wire tac_pkg::tac_nmi_t nmi_evt,
  output logic [tac_pkg::NFLAG-1:0] flag_clear,
  output logic busy,
  // Byte memory port.
  output logic mem_req,
  output tac_pkg::tac_mem_op_t mem_op,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import tac_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tac_state_t st_q;
  logic wait_q;
  logic [5:0] src_q;
  logic [4:0] set_q;
  logic [2:0] idx_q;
  logic first_q;
  logic [7:0] ccr_q;
  logic [7:0] cct_q;
  logic [7:0] rld_q;
  logic [15:0] sar_q;
  logic [15:0] dar_q;
  logic [7:0] dat_q;
  logic [NSRC-1:0] en_q;
  logic [NSRC-1:0] pend_q;
  logic evt_flag_q;
  logic rsvd_q;
  logic rd_one_q;
  logic dph_wr_q;
  logic [7:0] dph_idx_q;
  logic [31:0] hrdata_q;
  logic [NFLAG-1:0] flag_clear_q;
  logic busy_q;
  logic mm_go;
  logic mm_done;
  logic [7:0] mm_rdata;
  tac_mem_op_t mm_op;
  logic gnt_vld;
  logic [5:0] gnt_idx;
  logic take;
  logic xfer_done;
  logic hit0;
  logic end_clr;
  logic nmi_any;
  logic ap;
  logic ap_rd;
  logic [7:0] ap_idx;
  logic wr_actl;
  logic [31:0] rd_word;
  logic [3:0] wr_slot;
  logic [7:0] cnt_d;
  logic [15:0] cd_addr;

  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    logic [3:0] r;
    r = 4'h0;
    for (int s = 0; s < NSLOT; s++) begin
      if (idx == IDX_EN[s]) begin
        r = {1'h1, 3'(s)};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] next_idx(input logic [2:0] i,
                                          input logic [2:0] skip);
    return (i == skip) ? 3'(i + 3'h2) : 3'(i + 3'h1);
  endfunction

  function automatic logic [NFLAG-1:0] flag_of(input logic [5:0] s);
    return {s == SRC_FLASH, s == SRC_TMR_D, s == SRC_TMR_C,
            s == SRC_TMR_B, s == SRC_TMR_A};
  endfunction

  // ****************************************************************
  // Register slave
  // ****************************************************************
  // Only whole-word transfers occur, so hsize is not decoded.
  assign ap = hsel && htrans[1] && hready;
  assign ap_rd = ap && !hwrite;
  assign ap_idx = haddr[9:2];
  assign wr_actl = dph_wr_q && (dph_idx_q == IDX_ACTL);
  assign wr_slot = slot_of(dph_idx_q);
  assign nmi_any = nmi_evt.wdt | nmi_evt.osc | nmi_evt.vm1 | nmi_evt.vm2;

  always_comb begin
    logic [3:0] sl;
    sl = slot_of(ap_idx);
    rd_word = 32'h0000_0000;
    if (ap_idx == IDX_ACTL) begin
      rd_word[ACTL_EVT] = evt_flag_q;
      rd_word[ACTL_RSVD] = rsvd_q;
    end else if (sl[3]) begin
      rd_word[7:0] = en_q[{sl[2:0], 3'h0} +: 8];
    end
  end

  // Read data is registered in the address phase so that the bus
  // sees it straight from a flip-flop with no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'h0;
      dph_idx_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      dph_wr_q <= ap && hwrite;
      if (ap) begin
        dph_idx_q <= ap_idx;
      end
      if (ap_rd) begin
        hrdata_q <= rd_word;
      end
    end
  end

  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign hrdata = hrdata_q;

  // ****************************************************************
  // Event flag
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_flag_q <= ACTL_RESET[ACTL_EVT];
      rsvd_q <= ACTL_RESET[ACTL_RSVD];
      rd_one_q <= 1'h0;
    end else begin
      if (nmi_any) begin
        evt_flag_q <= 1'h1;
      end else if (wr_actl && !hwdata[ACTL_EVT] && rd_one_q) begin
        evt_flag_q <= 1'h0;
      end
      if (wr_actl) begin
        rsvd_q <= hwdata[ACTL_RSVD];
        rd_one_q <= 1'h0;
      end
      if (ap_rd && ap_idx == IDX_ACTL && evt_flag_q) begin
        rd_one_q <= 1'h1;
      end
    end
  end

  // ****************************************************************
  // Enables and pending requests
  // ****************************************************************
  assign take = (st_q == S_IDLE) && gnt_vld && !evt_flag_q;
  assign hit0 = cct_q == CNT_LAST;
  assign end_clr = first_q && hit0 &&
                   (!ccr_q[CCR_RPT] || ccr_q[CCR_RPT_IRQ]);
  assign xfer_done = (st_q == S_DWRITE) && mm_done;

  // A software write lands after the hardware clear, so a set wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= '0;
    end else begin
      if (xfer_done && end_clr) begin
        en_q[src_q] <= 1'h0;
      end
      if (dph_wr_q && wr_slot[3]) begin
        en_q[{wr_slot[2:0], 3'h0} +: 8] <= hwdata[7:0];
      end
    end
  end

  // Requests are taken here and never passed to the interrupt request
  // bit; the global interrupt mask plays no part.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q | (irq_src & {NSRC{!evt_flag_q}})) & en_q
                & ~(take ? (NSRC'(1) << gnt_idx) : '0);
    end
  end

  tac_arb u_arb (
    .pend(pend_q),
    .gnt_vld(gnt_vld),
    .gnt_idx(gnt_idx)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign cd_addr = CD_BASE + {8'h00, set_q, idx_q};
  assign cnt_d = (hit0 && ccr_q[CCR_RPT]) ? rld_q : 8'(cct_q - 8'h01);

  always_comb begin
    mm_op = '0;
    unique case (st_q)
      S_VEC: mm_op.addr = VEC_BASE + {10'h000, src_q};
      S_FETCH: mm_op.addr = cd_addr;
      S_DREAD: mm_op.addr = sar_q;
      S_DWRITE: begin
        mm_op.we = 1'h1;
        mm_op.addr = dar_q;
        mm_op.wdata = dat_q;
      end
      S_BACK: begin
        mm_op.we = 1'h1;
        mm_op.addr = cd_addr;
        unique case (idx_q)
          CD_CCT: mm_op.wdata = cct_q;
          CD_SAL: mm_op.wdata = sar_q[7:0];
          CD_SAH: mm_op.wdata = sar_q[15:8];
          CD_DAL: mm_op.wdata = dar_q[7:0];
          CD_DAH: mm_op.wdata = dar_q[15:8];
          default: mm_op.wdata = 8'h00;
        endcase
      end
      default: mm_op = '0;
    endcase
    mm_go = !wait_q && (st_q != S_IDLE) && (st_q != S_END);
  end

  tac_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(mm_go),
    .op(mm_op),
    .done_q(mm_done),
    .rdata_q(mm_rdata),
    .mem_req_q(mem_req),
    .mem_op_q(mem_op),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  // The flag is checked only in idle, so a running chain completes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= S_IDLE;
      wait_q <= 1'h0;
      src_q <= 6'h00;
      set_q <= 5'h00;
      idx_q <= 3'h0;
      first_q <= 1'h0;
    end else begin
      if (mm_go) begin
        wait_q <= 1'h1;
      end
      if (mm_done) begin
        wait_q <= 1'h0;
      end
      unique case (st_q)
        S_IDLE: if (take) begin
          src_q <= gnt_idx;
          first_q <= 1'h1;
          st_q <= S_VEC;
        end
        S_VEC: if (mm_done) begin
          set_q <= mm_rdata[4:0];
          idx_q <= CD_CCR;
          st_q <= S_FETCH;
        end
        S_FETCH: if (mm_done) begin
          idx_q <= next_idx(idx_q, CD_CCR);
          if (idx_q == CD_DAH) begin
            st_q <= S_DREAD;
          end
        end
        S_DREAD: if (mm_done) begin
          st_q <= S_DWRITE;
        end
        S_DWRITE: if (mm_done) begin
          idx_q <= CD_CCT;
          st_q <= S_BACK;
        end
        S_BACK: if (mm_done) begin
          idx_q <= next_idx(idx_q, CD_CCT);
          if (idx_q == CD_DAH) begin
            st_q <= S_END;
          end
        end
        S_END: if (ccr_q[CCR_CHAIN]) begin
          set_q <= 5'(set_q + 5'h01);
          idx_q <= CD_CCR;
          first_q <= 1'h0;
          st_q <= S_FETCH;
        end else begin
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Control data and data path
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ccr_q <= 8'h00;
      cct_q <= 8'h00;
      rld_q <= 8'h00;
      sar_q <= 16'h0000;
      dar_q <= 16'h0000;
      dat_q <= 8'h00;
    end else if (mm_done) begin
      if (st_q == S_FETCH) begin
        unique case (idx_q)
          CD_CCR: ccr_q <= mm_rdata;
          CD_CCT: cct_q <= mm_rdata;
          CD_RLD: rld_q <= mm_rdata;
          CD_SAL: sar_q[7:0] <= mm_rdata;
          CD_SAH: sar_q[15:8] <= mm_rdata;
          CD_DAL: dar_q[7:0] <= mm_rdata;
          CD_DAH: dar_q[15:8] <= mm_rdata;
          default: dat_q <= dat_q;
        endcase
      end
      if (st_q == S_DREAD) begin
        dat_q <= mm_rdata;
      end
      if (st_q == S_DWRITE) begin
        cct_q <= cnt_d;
        if (ccr_q[CCR_SINC]) begin
          sar_q <= 16'(sar_q + 16'h0001);
        end
        if (ccr_q[CCR_DINC]) begin
          dar_q <= 16'(dar_q + 16'h0001);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_clear_q <= '0;
      busy_q <= 1'h0;
    end else begin
      flag_clear_q <= (xfer_done && first_q && !end_clr) ?
                      flag_of(src_q) : '0;
      busy_q <= take || (st_q != S_IDLE && !(st_q == S_END &&
                !ccr_q[CCR_CHAIN]));
    end
  end

  assign flag_clear = flag_clear_q;
  assign busy = busy_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_flag_set:
    assert property (nmi_any |=> evt_flag_q)
    else $error("event flag not set by event");
  chk_flag_clear:
    assert property (wr_actl && !hwdata[ACTL_EVT] && rd_one_q &&
                     !nmi_any |=> !evt_flag_q)
    else $error("event flag not cleared");
  chk_flag_keep:
    assert property (evt_flag_q && !rd_one_q && !nmi_any |=> evt_flag_q)
    else $error("event flag cleared without prior read");
  chk_no_start:
    assert property (st_q == S_IDLE && evt_flag_q |=> st_q == S_IDLE)
    else $error("activation while event flag set");
  chk_finish:
    assert property (st_q == S_DREAD && evt_flag_q |=>
                     st_q inside {S_DREAD, S_DWRITE})
    else $error("transfer aborted");
  chk_rsvd_read:
    assert property (ap_rd && ap_idx == IDX_ACTL |=> hrdata_q[31:2] == '0)
    else $error("unassigned bits not zero");
  chk_cnt_dec:
    assert property (xfer_done && !ccr_q[CCR_RPT] |=>
                     cct_q == 8'($past(cct_q) - 8'h01))
    else $error("count not decremented");
  chk_cnt_reload:
    assert property (xfer_done && ccr_q[CCR_RPT] && hit0 |=>
                     cct_q == $past(rld_q))
    else $error("count not reloaded");
  chk_en_clear:
    assert property (xfer_done && end_clr && !dph_wr_q |=>
                     !en_q[$past(src_q)])
    else $error("enable bit not cleared");
  chk_grant_pend:
    assert property (take |-> pend_q[gnt_idx] ##1 st_q == S_VEC)
    else $error("grant without pending request");
  chk_walk_len:
    assert property (take |-> ##[20:1000] st_q inside {S_END, S_IDLE})
    else $error("activation did not reach its end");

  cov_chain: cover property (st_q == S_END && ccr_q[CCR_CHAIN]);
  cov_reload: cover property (xfer_done && ccr_q[CCR_RPT] && hit0);
  cov_blocked: cover property (gnt_vld && evt_flag_q && st_q == S_IDLE);
  cov_flag: cover property (flag_clear_q != '0);
endmodule

// ---- testbench/tac_mem_model.sv ----
// Behavioural byte memory standing on the far side of the memory port.
`timescale 1ns/10ps
module tac_mem_model (
  // Clock.
  input wire logic hclk,
  // Memory port.
  input wire logic mem_req,
  input wire tac_pkg::tac_mem_op_t mem_op,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Answer delay in cycles.
  input wire logic [3:0] dly
);
  import tac_pkg::*;
  logic [7:0] mem [0:65535];
  // The read data is inverted after every acknowledge cycle, writes too, so
  // a requester sampling late after a read never sees a plausible stale byte.
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'hA5;
    forever begin
      @(posedge hclk);
      if (mem_req === 1'b1) begin
        repeat (dly) @(posedge hclk);
        mem_ack <= 1'b1;
        if (mem_op.we) begin
          mem[mem_op.addr] <= mem_op.wdata;
        end else begin
          mem_rdata <= mem[mem_op.addr];
        end
        @(posedge hclk);
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule

// ---- testbench/transfer_activation_control_tb.sv ----
// Self-checking bench for the transfer activation control.
`timescale 1ns/10ps
module transfer_activation_control_tb;
  import tac_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic mem_req, mem_ack;
  wire logic hready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NSRC-1:0] irq_src;
  tac_nmi_t nmi_evt;
  logic [NFLAG-1:0] flag_clear;
  tac_mem_op_t mem_op;
  logic [7:0] mem_rdata;
  logic [3:0] dly;
  logic [15:0] wq [$];
  int err_total = 0;
  int total_checks = 0;
  int acks = 0;
  int fc_cnt = 0;
  int fc_b = 0;
  int fc_f = 0;
  assign hready = hreadyout;
  tac_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq_src(irq_src),
    .nmi_evt(nmi_evt), .flag_clear(flag_clear), .busy(busy),
    .mem_req(mem_req), .mem_op(mem_op), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  tac_mem_model pm (.hclk(hclk), .mem_req(mem_req), .mem_op(mem_op),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dly(dly));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (mem_req && mem_ack) begin
      acks <= acks + 1;
      if (mem_op.we && mem_op.addr[15:12] == 4'h3) begin
        wq.push_back(mem_op.addr);
      end
    end
    if (flag_clear[0]) begin
      fc_cnt <= fc_cnt + 1;
    end
    if (flag_clear[1]) begin
      fc_b <= fc_b + 1;
    end
    if (flag_clear[4]) begin
      fc_f <= fc_f + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The master waits on hready at every phase; the timeout ends a hang.
  task automatic ahb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    ahb(1'b1, idx, {24'h0, v});
  endtask
  task automatic rchk(input logic [7:0] idx, exp, input string nm);
    ahb(1'b0, idx, 32'h0);
    chk(nm, {24'h0, exp}, rd);
  endtask
  task automatic pulse(input logic [NSRC-1:0] m);
    @(posedge hclk);
    irq_src <= m;
    @(posedge hclk);
    irq_src <= '0;
  endtask
  task automatic nmi(input logic [3:0] m);
    @(posedge hclk);
    nmi_evt <= m;
    @(posedge hclk);
    nmi_evt <= '0;
  endtask
  task automatic await(input logic lvl, input int lim, input string nm);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(nm, {31'h0, lvl}, {31'h0, busy});
  endtask
  task automatic run;
    await(1'b1, 40, "busy rise");
    await(1'b0, 600, "busy fall");
  endtask
  task automatic setcd(input int s, input logic [7:0] ccr, cnt, rld,
                       input logic [15:0] sa, da);
    logic [15:0] b;
    b = CD_BASE + 16'(s * 8);
    pm.mem[b + CD_CCR] = ccr;
    pm.mem[b + CD_CCT] = cnt;
    pm.mem[b + CD_RLD] = rld;
    pm.mem[b + CD_SAL] = sa[7:0];
    pm.mem[b + CD_SAH] = sa[15:8];
    pm.mem[b + CD_DAL] = da[7:0];
    pm.mem[b + CD_DAH] = da[15:8];
  endtask
  function automatic logic [7:0] cd(input int s, input logic [2:0] o);
    return pm.mem[CD_BASE + 16'(s * 8) + o];
  endfunction
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic s_regs;
    chk("busy reset", 32'h0, {31'h0, busy});
    chk("mem_req reset", 32'h0, {31'h0, mem_req});
    chk("hresp", 32'h0, {31'h0, hresp});
    rchk(IDX_ACTL, ACTL_RESET, "actl reset");
    for (int k = 0; k < NSLOT; k++) begin
      rchk(IDX_EN[k], 8'h00, "enable reset");
    end
    wr(IDX_ACTL, 8'hFF);
    rchk(IDX_ACTL, 8'h01, "actl bits");
    wr(IDX_ACTL, 8'h00);
    wr(IDX_EN[3], 8'h5A);
    rchk(IDX_EN[3], 8'h5A, "enable rw");
    wr(IDX_EN[3], 8'h00);
    wr(8'h84, 8'hFF);
    rchk(8'h84, 8'h00, "unmapped");
  endtask
  task automatic s_flag;
    for (int k = 0; k < 4; k++) begin
      nmi(4'h8 >> k);
      // Each event has ended, standing for its interrupt
      // being disabled before software clears the flag.
      repeat (k == 0 ? 128 : 16) @(posedge hclk);
      wr(IDX_ACTL, 8'h00);
      rchk(IDX_ACTL, 8'h02, "flag set");
      wr(IDX_ACTL, 8'h00);
      rchk(IDX_ACTL, 8'h00, "flag clear");
    end
  endtask
  task automatic s_block;
    int a0;
    a0 = acks;
    pulse(48'h1 << 4);
    repeat (20) @(posedge hclk);
    chk("disabled source", a0, acks);
    nmi(4'h2);
    wr(IDX_EN[0], 8'h10);
    pulse(48'h1 << 4);
    repeat (30) @(posedge hclk);
    chk("flag blocks", a0, acks);
    rchk(IDX_ACTL, 8'h02, "flag up");
    wr(IDX_ACTL, 8'h00);
    wr(IDX_EN[0], 8'h00);
  endtask
  task automatic s_normal;
    dly = 4'h3;
    pm.mem[VEC_BASE + 16'd17] = 8'h03;
    setcd(3, 8'h08, 8'h02, 8'h00, 16'h1000, 16'h3000);
    pm.mem[16'h1000] = 8'hA5;
    pm.mem[16'h1001] = 8'h5A;
    wr(IDX_EN[2], 8'h02);
    pulse(48'h1 << 17);
    run;
    chk("dest byte", 32'hA5, {24'h0, pm.mem[16'h3000]});
    chk("count dec", 32'h01, {24'h0, cd(3, CD_CCT)});
    chk("src inc", 32'h01, {24'h0, cd(3, CD_SAL)});
    chk("dst fixed", 32'h00, {24'h0, cd(3, CD_DAL)});
    chk("timer flag", 32'h1, fc_cnt);
    rchk(IDX_EN[2], 8'h02, "enable kept");
    pulse(48'h1 << 17);
    run;
    chk("dest byte 2", 32'h5A, {24'h0, pm.mem[16'h3000]});
    chk("count zero", 32'h00, {24'h0, cd(3, CD_CCT)});
    chk("no timer flag", 32'h1, fc_cnt);
    rchk(IDX_EN[2], 8'h00, "enable cleared");
  endtask
  task automatic s_chain;
    dly = 4'h0;
    pm.mem[VEC_BASE + 16'd23] = 8'h05;
    setcd(5, 8'h15, 8'h01, 8'h04, 16'h1100, 16'h3100);
    setcd(6, 8'h00, 8'h03, 8'h00, 16'h1200, 16'h3200);
    pm.mem[16'h1100] = 8'h11;
    pm.mem[16'h1200] = 8'h22;
    wr(IDX_EN[2], 8'h80);
    pulse(48'h1 << 23);
    run;
    chk("chain first", 32'h11, {24'h0, pm.mem[16'h3100]});
    chk("reload", 32'h04, {24'h0, cd(5, CD_CCT)});
    chk("dst inc", 32'h01, {24'h0, cd(5, CD_DAL)});
    chk("chain second", 32'h22, {24'h0, pm.mem[16'h3200]});
    chk("second count", 32'h02, {24'h0, cd(6, CD_CCT)});
    rchk(IDX_EN[2], 8'h80, "repeat keeps");
  endtask
  task automatic s_prio;
    dly = 4'h1;
    wq.delete();
    pm.mem[VEC_BASE + 16'd7] = 8'h08;
    pm.mem[VEC_BASE + 16'd6] = 8'h09;
    setcd(8, 8'h00, 8'h00, 8'h00, 16'h1300, 16'h3300);
    setcd(9, 8'h00, 8'h05, 8'h00, 16'h1400, 16'h3400);
    pm.mem[16'h1300] = 8'h33;
    pm.mem[16'h1400] = 8'h44;
    pm.mem[16'h3400] = 8'h00;
    wr(IDX_EN[0], 8'hC0);
    pulse((48'h1 << 7) | (48'h1 << 6));
    await(1'b1, 40, "busy rise");
    nmi(4'h2);
    await(1'b0, 600, "busy fall");
    chk("first served", 32'h3300, {16'h0, wq[0]});
    chk("finishes", 32'h33, {24'h0, pm.mem[16'h3300]});
    chk("count 256", 32'hFF, {24'h0, cd(8, CD_CCT)});
    repeat (30) @(posedge hclk);
    chk("held off", 32'h00, {24'h0, pm.mem[16'h3400]});
    rchk(IDX_ACTL, 8'h02, "flag mid run");
    wr(IDX_ACTL, 8'h00);
    run;
    chk("next served", 32'h44, {24'h0, pm.mem[16'h3400]});
    rchk(IDX_EN[0], 8'hC0, "enables kept");
  endtask
  task automatic s_repeat_interrupt_enable;
    dly = 4'h2;
    pm.mem[VEC_BASE + 16'h0010] = 8'h0A;
    pm.mem[VEC_BASE + 16'h002B] = 8'h0B;
    setcd(10, 8'h03, 8'h01, 8'h07, 16'h1500, 16'h3500);
    setcd(11, 8'h01, 8'h01, 8'h09, 16'h1600, 16'h3600);
    pm.mem[16'h1500] = 8'h55;
    pm.mem[16'h1600] = 8'h66;
    wr(IDX_EN[2], 8'h01);
    wr(IDX_EN[5], 8'h08);
    pulse(48'h1 << 16);
    run;
    chk("repeat_interrupt_enable dest", 32'h55, {24'h0, pm.mem[16'h3500]});
    chk("repeat_interrupt_enable reload", 32'h07, {24'h0, cd(10, CD_CCT)});
    rchk(IDX_EN[2], 8'h00, "repeat_interrupt_enable clears");
    chk("no timer b flag", 32'h0, fc_b);
    pulse(48'h1 << 43);
    run;
    chk("flash dest", 32'h66, {24'h0, pm.mem[16'h3600]});
    chk("flash reload", 32'h09, {24'h0, cd(11, CD_CCT)});
    rchk(IDX_EN[5], 8'h08, "flash kept");
    chk("flash flag", 32'h1, fc_f);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_src = '0;
    nmi_evt = '0;
    dly = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs;
    s_flag;
    s_block;
    s_normal;
    s_chain;
    s_prio;
    s_repeat_interrupt_enable;
    results;
  end
  // All scenarios need about a thousand cycles; this leaves wide margin.
  initial begin
    #(100 * 20000);
    err_total++;
    results;
  end
endmodule
